//--- rtl/lcf_pkg.sv
// configuration constants, field layouts and state carrier for the lcd driver configuration block
// assumes a 20 MHz system clock and an 8-bit special-function register port
package lcf_pkg;

   // ----------------------------------------------------------------
   // register addresses and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MAIN_CFG_ADDR = 8'h95;
   localparam logic [7:0] SEC_CFG_ADDR = 8'h9C;
   localparam logic [7:0] MAIN_CFG_RESET = 8'h01;
   localparam logic [7:0] SEC_CFG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [7:0] SEC_CFG_WRITE_MASK = 8'h7F;

   // ----------------------------------------------------------------
   // field encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MUX_RESERVED = 2'h0;
   localparam logic [1:0] MUX_TWO = 2'h1;
   localparam logic [1:0] MUX_THREE = 2'h2;
   localparam logic [1:0] MUX_FOUR = 2'h3;
   localparam logic [1:0] FLASH_SW_OFF = 2'h0;
   localparam logic [1:0] FLASH_SW_ON = 2'h1;
   localparam logic [1:0] FLASH_FIXED_2HZ = 2'h2;
   localparam logic [1:0] FLASH_BY_RATE = 2'h3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int BASE_FAST_HZ = 2048;
   localparam int BASE_SLOW_HZ = 128;
   localparam int BASE_FAST_CYCLES = CLK_HZ / BASE_FAST_HZ;
   localparam int BASE_SLOW_CYCLES = CLK_HZ / BASE_SLOW_HZ;
   localparam int TICK_W = 18;
   // blink timing counted in quarter seconds of base ticks
   localparam int QTR_FAST_TICKS = BASE_FAST_HZ / 4;
   localparam int QTR_SLOW_TICKS = BASE_SLOW_HZ / 4;
   localparam int QTR_W = 10;
   // half periods in quarter seconds: 2 Hz, 1 Hz, 1/2 Hz, 1/3 Hz, 1/4 Hz
   localparam logic [3:0] HALF_2HZ = 4'h1;
   localparam logic [3:0] HALF_1HZ = 4'h2;
   localparam logic [3:0] HALF_1_2HZ = 4'h4;
   localparam logic [3:0] HALF_1_3HZ = 4'h6;
   localparam logic [3:0] HALF_1_4HZ = 4'h8;

   // ----------------------------------------------------------------
   // register layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic display_driver_on;
      logic display_memory_clear;
      logic flash_toggle_on;
      logic sleep_display_off;
      logic base_clock_choice;
      logic bias_third;
      logic [1:0] common_count_field;
   } lcf_main_cfg_s;

   typedef struct packed {
      logic reserved;
      logic external_ladder_choice;
      logic [5:0] contrast_level_field;
   } lcf_sec_cfg_s;

   // driver-facing outputs, all registered
   typedef struct packed {
      logic driver_run;
      logic memory_clear;
      logic display_visible;
      logic base_tick;
      logic bias_third;
      logic [1:0] common_count;
      logic pin_a_common;
      logic pin_b_common;
      logic [1:0] common_phase;
      logic ladder_on;
      logic pump_on;
      logic contrast_upper;
      logic [4:0] contrast_step;
   } lcf_drive_s;

   typedef struct packed {
      lcf_main_cfg_s main_cfg;
      lcf_sec_cfg_s sec_cfg;
      logic [7:0] rdata;
      logic [TICK_W-1:0] tick_cnt;
      logic [QTR_W-1:0] qtr_cnt;
      logic [3:0] half_cnt;
      logic blink_phase;
      lcf_drive_s drive;
   } lcf_state_s;

endpackage

//--- rtl/lcf_config.sv
// lcd driver configuration registers, base clock tick, blink phase and pin role decode
// assumes a synchronous 8-bit register port and sleep/timing fields from neighbouring logic

module lcf_config #(
   parameter int BASE_FAST_CYCLES = lcf_pkg::BASE_FAST_CYCLES,
   parameter int BASE_SLOW_CYCLES = lcf_pkg::BASE_SLOW_CYCLES,
   parameter int QTR_FAST_TICKS = lcf_pkg::QTR_FAST_TICKS,
   parameter int QTR_SLOW_TICKS = lcf_pkg::QTR_SLOW_TICKS
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // special-function register port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   // system status and timing fields
   input wire logic i_sleep_power_state,
   input wire logic [1:0] i_flash_source_field,
   input wire logic [1:0] i_flash_rate_field,
   // driver controls
   output lcf_pkg::lcf_drive_s o_drive
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   lcf_pkg::lcf_state_s state_r;
   lcf_pkg::lcf_state_s state_nxt;

   localparam logic [lcf_pkg::TICK_W-1:0] FAST_LAST = lcf_pkg::TICK_W'(BASE_FAST_CYCLES - 1);
   localparam logic [lcf_pkg::TICK_W-1:0] SLOW_LAST = lcf_pkg::TICK_W'(BASE_SLOW_CYCLES - 1);
   localparam logic [lcf_pkg::QTR_W-1:0] QTR_FAST_LAST = lcf_pkg::QTR_W'(QTR_FAST_TICKS - 1);
   localparam logic [lcf_pkg::QTR_W-1:0] QTR_SLOW_LAST = lcf_pkg::QTR_W'(QTR_SLOW_TICKS - 1);

   // ----------------------------------------------------------------
   // combinational helpers
   // ----------------------------------------------------------------
   logic run;
   logic base_tick;
   logic qtr_tick;
   logic [3:0] half_len;
   logic [1:0] last_phase;
   logic [lcf_pkg::TICK_W-1:0] tick_last;
   logic [lcf_pkg::QTR_W-1:0] qtr_last;
   logic wr_main;
   logic wr_sec;
   logic [7:0] rd_word;
   lcf_pkg::lcf_main_cfg_s main_wr;
   lcf_pkg::lcf_sec_cfg_s sec_wr;
   logic [lcf_pkg::TICK_W-1:0] tick_nxt;
   logic [lcf_pkg::QTR_W-1:0] qtr_nxt;
   logic [1:0] phase_nxt;
   logic flash_timed;
   logic [3:0] half_nxt;
   logic phase_flip;
   logic pin_a_role;
   logic pin_b_role;
   logic ladder_role;
   logic pump_role;
   logic visible_nxt;

   // ----------------------------------------------------------------
   // run gating
   // ----------------------------------------------------------------
   // sleep override only ever turns the display off, never on
   assign run = state_r.main_cfg.display_driver_on
      & ~(i_sleep_power_state & state_r.main_cfg.sleep_display_off);

   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   assign wr_main = i_sfr_wr && (i_sfr_addr == lcf_pkg::MAIN_CFG_ADDR);
   assign wr_sec = i_sfr_wr && (i_sfr_addr == lcf_pkg::SEC_CFG_ADDR);

   // a read alongside a write returns the contents before that write
   always_comb begin
      case (i_sfr_addr)
         lcf_pkg::MAIN_CFG_ADDR: rd_word = state_r.main_cfg;
         lcf_pkg::SEC_CFG_ADDR: rd_word = state_r.sec_cfg;
         default: rd_word = lcf_pkg::UNMAPPED_READ;
      endcase
   end

   // reserved top bit of the secondary register is never stored
   always_comb begin
      main_wr = state_r.main_cfg;
      sec_wr = state_r.sec_cfg;
      if (wr_main) begin
         main_wr = lcf_pkg::lcf_main_cfg_s'(i_sfr_wdata);
      end
      if (wr_sec) begin
         sec_wr = lcf_pkg::lcf_sec_cfg_s'(i_sfr_wdata & lcf_pkg::SEC_CFG_WRITE_MASK);
      end
   end

   // ----------------------------------------------------------------
   // base clock divider and common sequencing
   // ----------------------------------------------------------------
   always_comb begin
      if (state_r.main_cfg.base_clock_choice) begin
         tick_last = SLOW_LAST;
         qtr_last = QTR_SLOW_LAST;
      end else begin
         tick_last = FAST_LAST;
         qtr_last = QTR_FAST_LAST;
      end
   end

   // >= keeps a switch to the faster clock from stranding the count
   assign base_tick = run && (state_r.tick_cnt >= tick_last);
   assign qtr_tick = base_tick && (state_r.qtr_cnt >= qtr_last);

   always_comb begin
      tick_nxt = state_r.tick_cnt + 1'b1;
      qtr_nxt = state_r.qtr_cnt;
      if (base_tick) begin
         tick_nxt = '0;
         if (qtr_tick) begin
            qtr_nxt = '0;
         end else begin
            qtr_nxt = state_r.qtr_cnt + 1'b1;
         end
      end
   end

   // common phase wraps at the number of commons in use
   always_comb begin
      case (state_r.main_cfg.common_count_field)
         lcf_pkg::MUX_TWO: last_phase = 2'h1;
         lcf_pkg::MUX_THREE: last_phase = 2'h2;
         lcf_pkg::MUX_FOUR: last_phase = 2'h3;
         default: last_phase = 2'h0;
      endcase
   end

   always_comb begin
      phase_nxt = state_r.drive.common_phase;
      if (base_tick) begin
         if (state_r.drive.common_phase >= last_phase) begin
            phase_nxt = 2'h0;
         end else begin
            phase_nxt = state_r.drive.common_phase + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // blink timing
   // ----------------------------------------------------------------
   always_comb begin
      case (i_flash_rate_field)
         2'h0: half_len = lcf_pkg::HALF_1HZ;
         2'h1: half_len = lcf_pkg::HALF_1_2HZ;
         2'h2: half_len = lcf_pkg::HALF_1_3HZ;
         2'h3: half_len = lcf_pkg::HALF_1_4HZ;
         default: half_len = lcf_pkg::HALF_1HZ;
      endcase
      if (i_flash_source_field == lcf_pkg::FLASH_FIXED_2HZ) begin
         half_len = lcf_pkg::HALF_2HZ;
      end
   end

   // only the two timed sources advance the half-period count
   assign flash_timed = state_r.main_cfg.flash_toggle_on && i_flash_source_field[1];

   always_comb begin
      half_nxt = state_r.half_cnt;
      phase_flip = 1'b0;
      if (qtr_tick) begin
         if (state_r.half_cnt + 4'h1 >= half_len) begin
            half_nxt = '0;
            phase_flip = 1'b1;
         end else begin
            half_nxt = state_r.half_cnt + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin roles, bias supply and visibility
   // ----------------------------------------------------------------
   // both shared pins stay segments while idle or on the reserved code
   always_comb begin
      pin_a_role = 1'b0;
      pin_b_role = 1'b0;
      case (state_r.main_cfg.common_count_field)
         lcf_pkg::MUX_THREE: begin
            pin_b_role = run;
         end
         lcf_pkg::MUX_FOUR: begin
            pin_a_role = run;
            pin_b_role = run;
         end
         default: begin
            pin_a_role = 1'b0;
            pin_b_role = 1'b0;
         end
      endcase
   end

   // exactly one supply source is live while running, none while idle
   assign ladder_role = run && state_r.sec_cfg.external_ladder_choice;
   assign pump_role = run && !state_r.sec_cfg.external_ladder_choice;

   always_comb begin
      if (!run) begin
         visible_nxt = 1'b0;
      end else if (!state_r.main_cfg.flash_toggle_on) begin
         visible_nxt = 1'b1;
      end else begin
         case (i_flash_source_field)
            lcf_pkg::FLASH_SW_OFF: visible_nxt = 1'b0;
            lcf_pkg::FLASH_SW_ON: visible_nxt = 1'b1;
            default: visible_nxt = ~state_r.blink_phase;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;

      // register writes
      state_nxt.main_cfg = main_wr;
      state_nxt.sec_cfg = sec_wr;

      // register reads, answered one cycle later
      if (i_sfr_rd) begin
         state_nxt.rdata = rd_word;
      end

      // divider, common sequencing and blink phase
      if (!run) begin
         state_nxt.tick_cnt = '0;
         state_nxt.qtr_cnt = '0;
         state_nxt.half_cnt = '0;
         state_nxt.blink_phase = 1'b0;
         state_nxt.drive.common_phase = 2'h0;
      end else begin
         state_nxt.tick_cnt = tick_nxt;
         state_nxt.qtr_cnt = qtr_nxt;
         state_nxt.drive.common_phase = phase_nxt;
         if (!flash_timed) begin
            state_nxt.half_cnt = '0;
            state_nxt.blink_phase = 1'b0;
         end else begin
            state_nxt.half_cnt = half_nxt;
            state_nxt.blink_phase = state_r.blink_phase ^ phase_flip;
         end
      end

      // registered outputs: enable, clear, visibility and base tick
      state_nxt.drive.driver_run = run;
      state_nxt.drive.memory_clear = state_r.main_cfg.display_memory_clear;
      state_nxt.drive.display_visible = visible_nxt;
      state_nxt.drive.base_tick = base_tick;

      // waveform shape and pin roles
      state_nxt.drive.bias_third = state_r.main_cfg.bias_third;
      state_nxt.drive.common_count = state_r.main_cfg.common_count_field;
      state_nxt.drive.pin_a_common = pin_a_role;
      state_nxt.drive.pin_b_common = pin_b_role;

      // bias supply and contrast
      state_nxt.drive.ladder_on = ladder_role;
      state_nxt.drive.pump_on = pump_role;
      state_nxt.drive.contrast_upper = state_r.sec_cfg.contrast_level_field[5];
      state_nxt.drive.contrast_step = state_r.sec_cfg.contrast_level_field[4:0];
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= '0;
         state_r.main_cfg <= lcf_pkg::lcf_main_cfg_s'(lcf_pkg::MAIN_CFG_RESET);
         state_r.sec_cfg <= lcf_pkg::lcf_sec_cfg_s'(lcf_pkg::SEC_CFG_RESET);
         state_r.drive.common_count <= lcf_pkg::MUX_TWO;
      end else if (i_ce) begin
         state_r <= state_nxt;
      end
   end

   assign o_sfr_rdata = state_r.rdata;
   assign o_drive = state_r.drive;

endmodule

//--- test/lcf_config_props.sv
// assertions on the lcd configuration block ports
// assumes lcf_pkg addresses and the drive struct
module lcf_config_props #(
   parameter int BASE_FAST_CYCLES = 8, BASE_SLOW_CYCLES = 16,
   parameter int QTR_FAST_TICKS = 2, QTR_SLOW_TICKS = 2
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sleep_power_state,
   input wire lcf_pkg::lcf_drive_s o_drive
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   logic wm, ws, calm;
   assign wm = i_ce && i_sfr_wr && i_sfr_addr == lcf_pkg::MAIN_CFG_ADDR;
   assign ws = i_ce && i_sfr_wr && i_sfr_addr == lcf_pkg::SEC_CFG_ADDR;
   // the outputs take the write only on the next enabled edge, so the next cycle must be enabled and quiet
   assign calm = i_ce && !i_sfr_wr;
   a_main_run: assert property (wm ##1 calm |=> o_drive.driver_run ==
      ($past(i_sfr_wdata[7], 2) && !($past(i_sfr_wdata[4], 2) && $past(i_sleep_power_state))))
      else $error("run mismatch");
   a_main_shape: assert property (wm ##1 calm |=> o_drive.common_count == $past(i_sfr_wdata[1:0], 2) &&
      o_drive.bias_third == $past(i_sfr_wdata[2], 2)) else $error("bias or mux mismatch");
   a_clear_level: assert property (wm ##1 calm |=> o_drive.memory_clear == $past(i_sfr_wdata[6], 2))
      else $error("clear mismatch");
   a_sec_contrast: assert property (ws ##1 calm |=> o_drive.contrast_step == $past(i_sfr_wdata[4:0], 2) &&
      o_drive.contrast_upper == $past(i_sfr_wdata[5], 2)) else $error("contrast mismatch");
   a_supply_pick: assert property (o_drive.driver_run == (o_drive.ladder_on ^ o_drive.pump_on))
      else $error("ladder and pump clash");
   a_pin_roles: assert property (o_drive.driver_run |-> o_drive.pin_b_common == o_drive.common_count[1] &&
      o_drive.pin_a_common == (o_drive.common_count == lcf_pkg::MUX_FOUR)) else $error("pin role mismatch");
   a_idle_quiet: assert property (!o_drive.driver_run && !$past(o_drive.driver_run) |->
      o_drive.common_phase == 2'h0 && !o_drive.pin_a_common && !o_drive.pin_b_common && !o_drive.display_visible)
      else $error("idle outputs active");
   a_tick_pulse: assert property (o_drive.base_tick && i_ce |=> !o_drive.base_tick) else $error("tick too long");
endmodule
bind lcf_config lcf_config_props #(.BASE_FAST_CYCLES(BASE_FAST_CYCLES), .BASE_SLOW_CYCLES(BASE_SLOW_CYCLES),
   .QTR_FAST_TICKS(QTR_FAST_TICKS), .QTR_SLOW_TICKS(QTR_SLOW_TICKS)) props_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_ce(i_ce), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
   .i_sleep_power_state(i_sleep_power_state), .o_drive(o_drive));

//--- test/lcf_panel.sv
// panel stand-in: measures tick spacing and blink half periods
// assumes the drive struct of lcf_pkg, sampled on the rising clock
module lcf_panel (
   input wire logic i_clk,
   input wire lcf_pkg::lcf_drive_s i_drive,
   output int o_tick_gap,
   output int o_vis_gap
);
   timeunit 1ns;
   timeprecision 1ns;
   int tc = 0, vc = 0;
   logic vq = 1'b0;
   always @(posedge i_clk) begin
      tc++;
      vc++;
      if (i_drive.base_tick) begin
         o_tick_gap = tc;
         tc = 0;
      end
      if (i_drive.display_visible != vq) begin
         o_vis_gap = vc;
         vc = 0;
         vq = i_drive.display_visible;
      end
   end
endmodule

//--- test/lcf_config_bench.sv
// self-checking bench for the lcd configuration block
// assumes short counts: 8 cycles fast, 16 slow, 2 ticks a quarter
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module lcf_config_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, sleep = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, got, m = 8'h01, s = 8'h00, v;
   logic [1:0] src = 0, rate = 0;
   lcf_pkg::lcf_drive_s drv;
   int err_total = 0, tests_run = 0, tgap, vgap, hq;
   always #25 clk = ~clk;
   lcf_config #(.BASE_FAST_CYCLES(8), .BASE_SLOW_CYCLES(16), .QTR_FAST_TICKS(2), .QTR_SLOW_TICKS(2)) dut_u (
      .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
      .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_sleep_power_state(sleep),
      .i_flash_source_field(src), .i_flash_rate_field(rate), .o_drive(drv));
   lcf_panel panel_u (.i_clk(clk), .i_drive(drv), .o_tick_gap(tgap), .o_vis_gap(vgap));
   task automatic end_of_test;
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // outputs lag a write by two edges, so wait them out
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
      repeat (2) @(negedge clk);
   endtask
   task automatic rd8(input logic [7:0] a);
      @(negedge clk);
      addr = a;
      rd = 1;
      @(negedge clk);
      rd = 0;
      got = rdata;
   endtask
   task automatic check_cfg;
      logic run;
      run = m[7] & !(m[4] & sleep);
      `CHK(drv.driver_run, run)
      `CHK(drv.memory_clear, m[6])
      `CHK(drv.bias_third, m[2])
      `CHK({drv.common_count, drv.pin_a_common, drv.pin_b_common}, {m[1:0], run & (&m[1:0]), run & m[1]})
      `CHK({drv.ladder_on, drv.pump_on}, {run & s[6], run & !s[6]})
      `CHK({drv.contrast_upper, drv.contrast_step}, s[5:0])
      if (!run)
         `CHK({drv.common_phase, drv.display_visible}, 3'h0)
   endtask
   task automatic wait_tick;
      int n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (drv.base_tick !== 1'b1 && n < 40);
      @(negedge clk);
   endtask
   initial begin
      void'($urandom(46521));
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 0;
      check_cfg;
      for (int i = 0; i < 24; i++) begin
         v = 8'($urandom);
         // reference run drops whenever sleep is driven with the sleep-off bit set
         sleep = 1'($urandom);
         if (i % 3 == 2) begin
            wr8({4'h0, v[3:0]}, 8'($urandom));
            rd8({4'h0, v[3:0]});
            `CHK(got, 8'h00)
         end else if (i % 3 == 1) begin
            s = v;
            wr8(lcf_pkg::SEC_CFG_ADDR, s);
            rd8(lcf_pkg::SEC_CFG_ADDR);
            `CHK(got, s & 8'h7F)
         end else begin
            rd8(lcf_pkg::MAIN_CFG_ADDR);
            `CHK(got, m)
            m = {v[7:2], i[3:2]};
            wr8(lcf_pkg::MAIN_CFG_ADDR, m);
         end
         check_cfg;
      end
      ce = 0;
      wr8(lcf_pkg::MAIN_CFG_ADDR, ~m);
      ce = 1;
      rd8(lcf_pkg::MAIN_CFG_ADDR);
      `CHK(got, m)
      sleep = 0;
      for (int k = 0; k < 2; k++) begin
         wr8(lcf_pkg::MAIN_CFG_ADDR, k ? 8'h8A : 8'h83);
         repeat (40) @(negedge clk);
         `CHK(tgap, k ? 16 : 8)
         for (int j = 0; j < 4; j++) begin
            wait_tick;
            v[1:0] = drv.common_phase;
            wait_tick;
            `CHK(drv.common_phase, 2'((int'(v[1:0]) + 1) % (k ? 3 : 4)))
         end
      end
      wr8(lcf_pkg::MAIN_CFG_ADDR, 8'hA1);
      for (int b = 0; b < 7; b++) begin
         src = b < 3 ? 2'(b) : 2'h3;
         rate = 2'(b - 3);
         hq = src == 2'h2 ? 1 : 2 * (int'(rate) + 1);
         repeat (src[1] ? hq * 48 + 20 : 4) @(negedge clk);
         if (src[1])
            `CHK(vgap, hq * 16)
         else
            `CHK(drv.display_visible, src[0])
      end
      wr8(lcf_pkg::MAIN_CFG_ADDR, 8'h81);
      `CHK(drv.display_visible, 1'b1)
      // mid-run reset must bring back the reset contents
      rst = 1;
      @(negedge clk);
      rst = 0;
      m = 8'h01;
      s = 8'h00;
      check_cfg;
      rd8(lcf_pkg::SEC_CFG_ADDR);
      `CHK(got, s)
      m = 8'h03;
      wr8(lcf_pkg::MAIN_CFG_ADDR, m);
      check_cfg;
      end_of_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test;
   end
endmodule
